// >>> core/ams_link_if.sv
// ams_link_if: carrier between the sclk-side shifter and the core
// assumes: core words stay still while a frame is in progress
`timescale 1ns/1ps
`default_nettype none
interface ams_link_if;
   logic [15:0] cmd_word;
   logic cmd_tgl;
   logic [11:0] head_word;
   logic [11:0] cfg_word;
   logic head_out;
   logic hold_out;

   modport link (
      input head_word,
      input cfg_word,
      input head_out,
      input hold_out,
      output cmd_word,
      output cmd_tgl
   );

   modport core (
      output head_word,
      output cfg_word,
      output head_out,
      output hold_out,
      input cmd_word,
      input cmd_tgl
   );
endinterface
`default_nettype wire

// >>> core/ams_map.svh
// ams_map.svh: command codes, config field positions, reset values, timing
// assumes: included by bare name from the core and link design files
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

// serial frame: 16 bits, command nibble first, then 12 data bits
`define AMS_BIT_DECODE 4'h3
`define AMS_BIT_LAST 4'hF
`define AMS_HEAD_BITS 4'hC
`define AMS_HEAD_MSB 4'hB

// command nibble codes; 0 to 7 select a channel
`define AMS_CMD_PWDN 4'h8
`define AMS_CMD_READ_CFG 4'h9
`define AMS_CMD_WRITE_CFG 4'hA
`define AMS_CMD_READ_FIFO 4'hE

// config word fields
`define AMS_CFG_THR_LSB 0
`define AMS_CFG_SEQ_LSB 2
`define AMS_CFG_EXT_BIT 4
`define AMS_CFG_MODE_LSB 5
`define AMS_CFG_EOC_BIT 7
`define AMS_CFG_RESET 12'h000

// fifo thresholds in entries
`define AMS_FIFO_DEPTH 4'h8
`define AMS_THR_3Q 4'h6
`define AMS_THR_HALF 4'h4
`define AMS_THR_1Q 4'h2
`define AMS_THR_ONE 4'h1

// synchroniser reset {tgl, pwdn, conversion_start_pin, fs, cs}
`define AMS_SYNC_RESET 5'h0F

// conversion time: 14 clocks of the 4 MHz converter clock
`define AMS_SYS_CLK_NS 50
`define AMS_CONV_NS 3500
`define AMS_CONV_CYC ((`AMS_CONV_NS + `AMS_SYS_CLK_NS - 1) / `AMS_SYS_CLK_NS)

`endif

// >>> core/ams_pkg.sv
// ams_pkg: types shared by the sequencer core and its serial link
// assumes: compiled before every other file of the block
package ams_pkg;

   typedef enum logic [1:0] {
      MODE_ONE_SHOT = 2'h0,
      MODE_REPEAT = 2'h1,
      MODE_SWEEP = 2'h2,
      MODE_REPEAT_SWEEP = 2'h3
   } ams_mode_t;

   typedef enum logic {
      ST_IDLE,
      ST_CONV
   } ams_conv_st_t;

endpackage

// >>> core/ams_seq_top.sv
// ams_seq_top: mode sequencer, result fifo and event logic of the converter
// assumes: sclk from the host, analog core answers adc_data on sys_clk
//
// Functional notes
// [RQ1] config bits 6:5 pick one shot, repeat, sweep or repeating sweep
// [RQ2] sweep converts list channels in order, stops early at fifo threshold
// [RQ3] after sweep threshold, interrupt; no new sweep until fifo read empty
// [RQ4] repeating sweep raises interrupt at threshold and keeps sweeping
// [RQ5] repeating sweep: fifo read right after interrupt keeps results in order
// [RQ6] repeating sweep: other command or new start empties fifo first
// [RQ7] one shot normal: frame selects, samples, converts; one event each
// [RQ8] one shot extended: frames select and read, start pin converts
// [RQ9] fifo modes: one interrupt at threshold; unread service clears fifo
// [RQ10] extended sampling: start pin triggers only while chip select high
// [RQ11] event pin is end of conversion only in one shot mode
// [RQ12] host drops start pin within 2.5 us of the select frame
// [RQ13] config read decoded in 4 clocks, word shifted out after
// [RQ14] first frame after interrupt shows oldest fifo entry at once
// [RQ15] non fifo-read command stops output, oldest entry is kept
// [RQ16] read cycles start no conversion and raise no event
// [RQ17] write cycle loads 12-bit config word, no conversion or event
// [RQ18] fifo has eight entries, threshold programmable, one in one shot
// [RQ19] power-down empties fifo, restarts sweep, keeps config word
// [RQ20] start pin rising edge begins conversion, low time is sampling
// [RQ21] interrupt stays until the next command is decoded
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"
module ams_seq_top (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic frame_sync_input_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe_n,
   input wire logic conversion_start_pin_n,
   input wire logic pwdn_n,
   input wire logic [11:0] adc_data,
   output logic adc_sample,
   output logic adc_convert,
   output logic [2:0] adc_channel,
   output logic eoc_int_n,
   output ams_pkg::ams_mode_t cur_mode,
   output logic [11:0] config_word,
   output logic [3:0] fifo_level
);
   import ams_pkg::*;

   localparam int conv_cyc = `AMS_CONV_CYC;

   function automatic logic [3:0] thr_count(input logic one,
      input logic [1:0] sel);
      logic [3:0] t;
      t = `AMS_FIFO_DEPTH;
      if (one) begin
         t = `AMS_THR_ONE;
      end else begin
         unique case (sel)
            2'h0: t = `AMS_FIFO_DEPTH;
            2'h1: t = `AMS_THR_3Q;
            2'h2: t = `AMS_THR_HALF;
            2'h3: t = `AMS_THR_1Q;
         endcase
      end
      return t;
   endfunction

   function automatic logic [2:0] sweep_chan(input logic [1:0] seq,
      input logic [2:0] idx);
      logic [2:0] c;
      c = 3'h0;
      unique case (seq)
         2'h0: c = {1'b0, idx[1:0]};
         2'h1: c = {idx[1:0], 1'b0};
         2'h2: c = {idx[2:1], 1'b0};
         2'h3: c = {1'b0, idx[0], 1'b0};
      endcase
      return c;
   endfunction

   ams_link_if lk ();
   logic [1:0] lrst_ff;

   ams_serial_link ams_serial_link_inst (
      .sclk(sclk),
      .link_rst(lrst_ff[1]),
      .cs_n(cs_n),
      .frame_sync_input_n(frame_sync_input_n),
      .sdi(sdi),
      .sdo(sdo),
      .sdo_oe_n(sdo_oe_n),
      .lk(lk)
   );

   // reset carried into the sclk domain
   always_ff @(posedge sclk) begin
      lrst_ff <= {lrst_ff[0], srst};
   end

   // pin and toggle synchronisers, then edge history
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] hist_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_ff <= `AMS_SYNC_RESET;
         sync2_ff <= `AMS_SYNC_RESET;
         hist_ff <= `AMS_SYNC_RESET;
      end else begin
         sync1_ff <= {lk.cmd_tgl, pwdn_n, conversion_start_pin_n,
            frame_sync_input_n, cs_n};
         sync2_ff <= sync1_ff;
         hist_ff <= sync2_ff;
      end
   end

   logic [11:0] config_word_ff;
   logic [2:0] sel_chan_ff;
   logic [2:0] conv_chan_ff;
   logic [2:0] sweep_idx_ff;
   logic sweep_done_ff;
   ams_conv_st_t st_ff;
   logic [6:0] conv_cnt_ff;
   logic int_pend_ff;
   logic reading_ff;
   logic flush_ff;
   logic frame_ff;
   logic [11:0] fifo_mem [0:7];
   logic [2:0] rd_ptr_ff;
   logic [2:0] wr_ptr_ff;
   logic [3:0] cnt_ff;
   logic [11:0] head_ff;
   logic [11:0] cfg_shadow_ff;
   logic head_out_ff;
   logic hold_out_ff;
   logic eoc_int_n_ff;
   logic adc_sample_ff;
   logic [6:0] conv_age_ff;

   // decoding of synchronised pins and the command word
   wire logic cs_s = sync2_ff[0];
   wire logic fs_s = sync2_ff[1];
   wire logic cst_s = sync2_ff[2];
   wire logic pwdn_s = sync2_ff[3];
   wire logic cmd_evt = sync2_ff[4] ^ hist_ff[4];
   wire logic cst_rise = cst_s && !hist_ff[2];
   wire logic cst_fall = !cst_s && hist_ff[2];
   wire logic frame_start = (!cs_s && hist_ff[0]) || (!fs_s && hist_ff[1]);
   wire logic [3:0] cmd = lk.cmd_word[15:12];
   wire logic [11:0] cmd_data = lk.cmd_word[11:0];
   wire logic is_sel = cmd_evt && !cmd[3];
   wire logic is_rf = cmd_evt && cmd == `AMS_CMD_READ_FIFO;
   wire logic is_wr = cmd_evt && cmd == `AMS_CMD_WRITE_CFG; // [RQ17]
   wire logic pd_evt = (cmd_evt && cmd == `AMS_CMD_PWDN) || !pwdn_s;

   // configuration fields
   wire ams_mode_t mode = ams_mode_t'(config_word_ff[`AMS_CFG_MODE_LSB +: 2]);
   wire logic oneshot = mode == MODE_ONE_SHOT; // [RQ1]
   wire logic sweeping = mode == MODE_SWEEP || mode == MODE_REPEAT_SWEEP;
   wire logic ext = config_word_ff[`AMS_CFG_EXT_BIT];
   wire logic eoc_fn = config_word_ff[`AMS_CFG_EOC_BIT];
   wire logic [3:0] thr = thr_count(oneshot,
      config_word_ff[`AMS_CFG_THR_LSB +: 2]); // [RQ18]
   // outside sweep modes, a select frame that also triggers converts the channel it names
   wire logic [2:0] pick_chan = is_sel ? cmd[2:0] : sel_chan_ff; // [RQ8]
   wire logic [2:0] next_chan = sweeping ?
      sweep_chan(config_word_ff[`AMS_CFG_SEQ_LSB +: 2], sweep_idx_ff) :
      pick_chan;

   // conversion trigger: select frame, or start pin rising while cs high
   wire logic busy = st_ff == ST_CONV;
   wire logic trig = ext ? (cst_rise && cs_s) : is_sel; // [RQ10] [RQ20] [RQ7]
   wire logic halted = mode == MODE_SWEEP && sweep_done_ff; // [RQ3]
   wire logic conv_go = trig && !busy && !pd_evt && !halted && !srst;
   wire logic conv_done = busy && conv_cnt_ff == 7'h00;

   // fifo control
   wire logic svc_flush = cmd_evt && int_pend_ff && !oneshot &&
      cmd != `AMS_CMD_READ_FIFO; // [RQ9] [RQ6]
   wire logic push = conv_done && !pd_evt && !srst;
   wire logic flush_now = pd_evt || svc_flush ||
      (push && (flush_ff || oneshot)); // [RQ19] [RQ6] [RQ18]
   wire logic push_ok = push && (flush_now || cnt_ff != `AMS_FIFO_DEPTH);
   wire logic pop = cnt_ff != 4'h0 && (oneshot ? (is_sel || is_rf) :
      (is_rf && (int_pend_ff || reading_ff))); // [RQ5] [RQ15]
   wire logic [3:0] nxt_cnt = flush_now ? {3'h0, push_ok} :
      cnt_ff + {3'h0, push_ok} - {3'h0, pop};
   wire logic [2:0] wr_idx = flush_now ? 3'h0 : wr_ptr_ff;
   wire logic hit_thr = push_ok && nxt_cnt == thr; // [RQ9] [RQ4] [RQ7]
   wire logic sweep_end = hit_thr || sweep_idx_ff == 3'h7; // [RQ2]

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         config_word_ff <= `AMS_CFG_RESET;
      end else if (is_wr) begin
         config_word_ff <= cmd_data; // [RQ17] [RQ19]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sel_chan_ff <= 3'h0;
      end else if (is_sel) begin
         sel_chan_ff <= cmd[2:0]; // [RQ8]
      end
   end

   // conversion engine; reads and writes never reach conv_go
   always_ff @(posedge sys_clk) begin
      if (srst || pd_evt) begin
         st_ff <= ST_IDLE;
         conv_cnt_ff <= 7'h00;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               if (conv_go) begin // [RQ16]
                  st_ff <= ST_CONV;
                  conv_cnt_ff <= 7'(conv_cyc - 1);
               end
            end
            ST_CONV: begin
               if (conv_done) begin
                  st_ff <= ST_IDLE;
               end else begin
                  conv_cnt_ff <= conv_cnt_ff - 7'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         conv_chan_ff <= 3'h0;
      end else if (conv_go) begin
         conv_chan_ff <= next_chan;
      end
   end

   // sweep position; a sweep halts at its end until the fifo is read empty
   always_ff @(posedge sys_clk) begin
      if (srst || pd_evt || is_wr) begin
         sweep_idx_ff <= 3'h0; // [RQ19]
         sweep_done_ff <= 1'b0;
      end else if (push_ok && sweeping) begin
         sweep_idx_ff <= sweep_idx_ff + 3'h1;
         sweep_done_ff <= mode == MODE_SWEEP && sweep_end; // [RQ2] [RQ4]
      end else if (sweep_done_ff && reading_ff && nxt_cnt == 4'h0) begin
         sweep_idx_ff <= 3'h0; // [RQ3]
         sweep_done_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || flush_now) begin
         rd_ptr_ff <= 3'h0;
         wr_ptr_ff <= {2'h0, push_ok};
      end else begin
         rd_ptr_ff <= rd_ptr_ff + {2'h0, pop};
         wr_ptr_ff <= wr_ptr_ff + {2'h0, push_ok};
      end
   end

   always_ff @(posedge sys_clk) begin
      cnt_ff <= srst ? 4'h0 : nxt_cnt;
   end

   always_ff @(posedge sys_clk) begin
      if (push_ok) begin
         fifo_mem[wr_idx] <= adc_data;
      end
   end

   // interrupt: set at threshold, held until next command; set wins
   always_ff @(posedge sys_clk) begin
      if (srst || pd_evt) begin
         int_pend_ff <= 1'b0;
      end else if (hit_thr) begin
         int_pend_ff <= 1'b1; // [RQ9] [RQ3]
      end else if (cmd_evt) begin
         int_pend_ff <= 1'b0; // [RQ21]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || pd_evt) begin
         reading_ff <= 1'b0;
      end else if (pop && !oneshot && nxt_cnt != 4'h0) begin
         reading_ff <= 1'b1; // [RQ5]
      end else if (cmd_evt || nxt_cnt == 4'h0) begin
         reading_ff <= 1'b0;
      end
   end

   // in repeating sweep, a new start pulse after an ignored interrupt empties the fifo first
   always_ff @(posedge sys_clk) begin
      if (srst || pd_evt) begin
         flush_ff <= 1'b0;
      end else if (mode == MODE_REPEAT_SWEEP && int_pend_ff && ext &&
         cst_fall) begin
         flush_ff <= 1'b1; // [RQ6]
      end else if (push_ok) begin
         flush_ff <= 1'b0;
      end
   end

   // words seen by the link are frozen from frame start to command
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         frame_ff <= 1'b0;
      end else if (frame_start) begin
         frame_ff <= 1'b1;
      end else if (cmd_evt) begin
         frame_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         head_ff <= 12'h000;
         cfg_shadow_ff <= `AMS_CFG_RESET;
         head_out_ff <= 1'b0;
         hold_out_ff <= 1'b0;
      end else if (!frame_ff && !frame_start) begin
         head_ff <= fifo_mem[rd_ptr_ff];
         cfg_shadow_ff <= config_word_ff;
         head_out_ff <= cnt_ff != 4'h0 &&
            (oneshot || int_pend_ff || reading_ff); // [RQ14]
         hold_out_ff <= oneshot; // [RQ8]
      end
   end

   assign lk.head_word = head_ff;
   assign lk.cfg_word = cfg_shadow_ff;
   assign lk.head_out = head_out_ff;
   assign lk.hold_out = hold_out_ff;

   // event pin and converter outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         eoc_int_n_ff <= 1'b1;
         adc_sample_ff <= 1'b0;
      end else begin
         eoc_int_n_ff <= (oneshot && eoc_fn) ? !busy : !int_pend_ff; // [RQ11]
         adc_sample_ff <= ext ? (!cst_s && cs_s) : frame_ff; // [RQ20]
      end
   end

   assign eoc_int_n = eoc_int_n_ff;
   assign adc_sample = adc_sample_ff;
   assign adc_convert = busy;
   assign adc_channel = conv_chan_ff;
   assign cur_mode = mode;
   assign config_word = config_word_ff;
   assign fifo_level = cnt_ff;

   // helper: cycles spent in the current conversion
   always_ff @(posedge sys_clk) begin
      if (srst || conv_go) begin
         conv_age_ff <= 7'h00;
      end else if (busy) begin
         conv_age_ff <= conv_age_ff + 7'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   conv_time_a: assert property ( // [RQ20]
      conv_done |-> conv_age_ff == 7'(conv_cyc - 1))
      else $error("conversion length wrong");
   int_thr_a: assert property ( // [RQ9]
      $rose(int_pend_ff) |-> cnt_ff == $past(thr))
      else $error("interrupt without threshold");
   int_hold_a: assert property ( // [RQ21]
      int_pend_ff && !cmd_evt && !pd_evt |=> int_pend_ff)
      else $error("interrupt dropped early");
   int_pin_a: assert property ( // [RQ11]
      !oneshot ##1 !oneshot |-> eoc_int_n == !$past(int_pend_ff))
      else $error("event pin not interrupt in fifo mode");
   svc_clear_a: assert property ( // [RQ9]
      svc_flush && !push_ok |=> cnt_ff == 4'h0)
      else $error("fifo not cleared on unread service");
   read_keep_a: assert property ( // [RQ5]
      reading_ff && is_rf && !push_ok && !pd_evt && cnt_ff != 4'h0
      |=> cnt_ff == $past(cnt_ff) - 4'h1)
      else $error("fifo read lost entries");
   sweep_halt_a: assert property ( // [RQ3]
      halted && !busy |=> !busy)
      else $error("sweep restarted before fifo read");
   read_noconv_a: assert property ( // [RQ16]
      cmd_evt && !ext && (cmd == `AMS_CMD_READ_FIFO ||
      cmd == `AMS_CMD_READ_CFG) |-> !conv_go)
      else $error("read cycle started a conversion");
   cfg_write_a: assert property ( // [RQ17]
      is_wr && !busy && !ext |=> config_word_ff == $past(cmd_data) && !busy)
      else $error("config write wrong");
   pd_clear_a: assert property ( // [RQ19]
      pd_evt && !is_wr |=> cnt_ff == 4'h0 &&
      config_word_ff == $past(config_word_ff) && sweep_idx_ff == 3'h0)
      else $error("power down did not clear fifo");

   sweep_int_c: cover property (mode == MODE_SWEEP && $rose(int_pend_ff));
   rsweep_flush_c: cover property (mode == MODE_REPEAT_SWEEP && svc_flush);
   drain_c: cover property (reading_ff ##1 !reading_ff && cnt_ff == 4'h0);

endmodule // ams_seq_top
`default_nettype wire

// >>> core/ams_serial_link.sv
// ams_serial_link: serial frame shifter on the host's sclk
// assumes: sclk runs inside frames and while the link reset is applied; frames are 16 sclk rising edges
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"
module ams_serial_link (
   input wire logic sclk,
   input wire logic link_rst,
   input wire logic cs_n,
   input wire logic frame_sync_input_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe_n,
   ams_link_if.link lk
);
   import ams_pkg::*;

   logic [3:0] bit_cnt_ff;
   logic [14:0] shift_ff;
   logic dec_fifo_ff;
   logic dec_cfg_ff;
   logic cmd_tgl_ff;
   logic [15:0] cmd_word_ff;

   wire logic ena = !cs_n && frame_sync_input_n;
   wire logic [3:0] cmd_nib = {shift_ff[2:0], sdi};
   wire logic decoded = bit_cnt_ff > `AMS_BIT_DECODE;
   wire logic [3:0] head_idx = `AMS_HEAD_MSB - bit_cnt_ff;
   wire logic [3:0] cfg_idx = `AMS_BIT_LAST - bit_cnt_ff;
   // head shown from the first bit, dropped after decode unless a fifo read or hold_out is set
   wire logic show_head = lk.head_out && (lk.hold_out || !decoded ||
      dec_fifo_ff); // [RQ14] [RQ15]
   wire logic show_cfg = decoded && dec_cfg_ff; // [RQ13]
   wire logic head_bit = (bit_cnt_ff < `AMS_HEAD_BITS) ?
      lk.head_word[head_idx] : 1'b0;

   assign sdo = show_cfg ? lk.cfg_word[cfg_idx] : (show_head && head_bit);
   assign sdo_oe_n = cs_n || !(show_head || show_cfg);
   assign lk.cmd_word = cmd_word_ff;
   assign lk.cmd_tgl = cmd_tgl_ff;

   // frame sync low restarts the count; that edge carries no data
   always_ff @(posedge sclk) begin
      if (link_rst || !frame_sync_input_n) begin
         bit_cnt_ff <= 4'h0;
      end else if (!cs_n) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge sclk) begin
      if (link_rst) begin
         shift_ff <= 15'h0000;
      end else if (ena) begin
         shift_ff <= {shift_ff[13:0], sdi};
      end
   end

   // command decoded on the fourth clock
   always_ff @(posedge sclk) begin
      if (link_rst) begin
         dec_fifo_ff <= 1'b0;
         dec_cfg_ff <= 1'b0;
      end else if (ena && bit_cnt_ff == `AMS_BIT_DECODE) begin
         dec_fifo_ff <= cmd_nib == `AMS_CMD_READ_FIFO; // [RQ15]
         dec_cfg_ff <= cmd_nib == `AMS_CMD_READ_CFG; // [RQ13]
      end
   end

   // whole word handed to the core by a toggle
   always_ff @(posedge sclk) begin
      if (link_rst) begin
         cmd_word_ff <= 16'h0000;
         cmd_tgl_ff <= 1'b0;
      end else if (ena && bit_cnt_ff == `AMS_BIT_LAST) begin
         cmd_word_ff <= {shift_ff, sdi};
         cmd_tgl_ff <= !cmd_tgl_ff;
      end
   end

   property p_cfg_read;
      @(posedge sclk) disable iff (link_rst)
      ena && bit_cnt_ff == `AMS_BIT_DECODE && cmd_nib == `AMS_CMD_READ_CFG
      |=> cs_n || (!sdo_oe_n && sdo == lk.cfg_word[11]);
   endproperty
   cfg_read_out_a: assert property (p_cfg_read) // [RQ13]
      else $error("config word not driven after decode");

   out_stop_a: assert property ( // [RQ15]
      @(posedge sclk) disable iff (link_rst)
      ena && bit_cnt_ff == `AMS_BIT_DECODE && !lk.hold_out &&
      cmd_nib != `AMS_CMD_READ_FIFO && cmd_nib != `AMS_CMD_READ_CFG
      |=> sdo_oe_n || cs_n)
      else $error("output not stopped after non fifo command");

endmodule // ams_serial_link
`default_nettype wire

// >>> test/ams_host_model.sv
// ams_host_model: host serial port, 16-bit frames on an 80 ns sclk
// assumes: frame sync unused; sclk stands low between frames
`timescale 1ns/1ps
`default_nettype none
module ams_host_model (
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe_n
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // sclk pulses with chip select high, for the link reset
   task automatic idle_clk(input int n);
      repeat (n) begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
   endtask
   // r holds sdo seen before each rising edge, inverted while sdo_oe_n is high; oe_n5 before the fifth
   task automatic xfer(input logic [15:0] w, output logic [15:0] r,
         output logic oe_n5);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #40 r[i] = sdo_oe_n ? !sdo : sdo;
         if (i == 11) oe_n5 = sdo_oe_n;
         sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      // released line shows the inverse of its last value
      sdi = ~sdi;
   endtask
endmodule // ams_host_model
`default_nettype wire

// >>> test/ams_seq_top_test.sv
// ams_seq_top_test: frame sequences through the host model, per mode
// assumes: adc_data answers with a pattern tagged by the channel
`timescale 1ns/1ps
`default_nettype none
module ams_seq_top_test;
   import ams_pkg::*;
   logic sys_clk, srst, sclk, cs_n, sdi, sdo, sdo_oe_n, start_n, pwdn_n;
   logic adc_sample, adc_convert, eoc_int_n, oe5;
   logic [2:0] adc_channel;
   logic [11:0] adc_data, config_word;
   logic [3:0] fifo_level;
   logic [15:0] rd;
   ams_mode_t cur_mode;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   ams_host_model ams_host_model_inst (.sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
   ams_seq_top ams_seq_top_inst (.sys_clk(sys_clk), .srst(srst),
      .sclk(sclk), .cs_n(cs_n), .frame_sync_input_n(1'b1), .sdi(sdi),
      .sdo(sdo), .sdo_oe_n(sdo_oe_n), .conversion_start_pin_n(start_n),
      .pwdn_n(pwdn_n), .adc_data(adc_data), .adc_sample(adc_sample),
      .adc_convert(adc_convert), .adc_channel(adc_channel),
      .eoc_int_n(eoc_int_n), .cur_mode(cur_mode),
      .config_word(config_word), .fifo_level(fifo_level));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      adc_data <= #1 {9'h150, adc_channel};
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic frame(input logic [15:0] w);
      ams_host_model_inst.xfer(w, rd, oe5);
      cw(10);
   endtask
   // waits out one conversion, checks channel and event pin meanwhile
   task automatic conv(input logic [2:0] ch, input logic eoc);
      for (int k = 0; k < 100 && adc_convert !== 1'b1; k++) cw(1);
      chk({15'h0, adc_convert}, 16'h0001);
      chk({13'h0, adc_channel}, {13'h0, ch});
      chk({15'h0, eoc_int_n}, {15'h0, eoc});
      for (int k = 0; k < 100 && adc_convert !== 1'b0; k++) cw(1);
      cw(4);
   endtask
   task automatic quiet();
      chk({15'h0, adc_convert}, 16'h0000);
   endtask
   initial begin
      srst = 1'b1;
      start_n = 1'b1;
      pwdn_n = 1'b1;
      fork
         ams_host_model_inst.idle_clk(4);
         repeat (10) @(posedge sys_clk);
      join
      #1 srst = 1'b0;
      ams_host_model_inst.idle_clk(2);
      cw(4);
      chk({4'h0, config_word}, 16'h0000);
      chk({12'h0, fifo_level}, 16'h0000);
      chk({15'h0, eoc_int_n}, 16'h0001);
      for (int m = 0; m < 4; m++) begin
         frame({4'hA, 5'h00, 2'(m), 5'h00});
         chk({14'h0, cur_mode}, {14'h0, 2'(m)});
      end
      frame(16'hA042);
      chk({4'h0, config_word}, 16'h0042);
      quiet();
      frame(16'h9000);
      chk({4'h0, rd[11:0]}, 16'h0042);
      quiet();
      chk({15'h0, eoc_int_n}, 16'h0001);
      $display("test config done");
      for (int i = 0; i < 4; i++) begin
         frame(16'h0000);
         conv(3'(i), 1'b1);
      end
      chk({12'h0, fifo_level}, 16'h0004);
      chk({15'h0, eoc_int_n}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         frame(16'hE000);
         chk({4'h0, rd[15:4]}, {4'h0, 9'h150, 3'(i)});
         quiet();
         chk({15'h0, eoc_int_n}, 16'h0001);
      end
      chk({12'h0, fifo_level}, 16'h0000);
      frame(16'h0000);
      conv(3'h0, 1'b1);
      @(posedge sys_clk) #1 pwdn_n = 1'b0;
      cw(3);
      pwdn_n = 1'b1;
      chk({12'h0, fifo_level}, 16'h0000);
      chk({4'h0, config_word}, 16'h0042);
      $display("test sweep done");
      frame(16'hA063);
      for (int i = 0; i < 2; i++) begin
         frame(16'h0000);
         conv(3'(i), 1'b1);
      end
      chk({15'h0, eoc_int_n}, 16'h0000);
      frame(16'h0000);
      chk({15'h0, oe5}, 16'h0001);
      conv(3'h2, 1'b1);
      chk({12'h0, fifo_level}, 16'h0001);
      frame(16'h0000);
      conv(3'h3, 1'b1);
      for (int i = 2; i < 4; i++) begin
         frame(16'hE000);
         chk({4'h0, rd[15:4]}, {4'h0, 9'h150, 3'(i)});
      end
      $display("test repeat sweep done");
      frame(16'hA0A3);
      for (int i = 0; i < 2; i++) begin
         frame(16'h6000);
         conv(3'h6, 1'b1);
      end
      chk({12'h0, fifo_level}, 16'h0002);
      chk({15'h0, eoc_int_n}, 16'h0000);
      frame(16'hA080);
      chk({12'h0, fifo_level}, 16'h0000);
      frame(16'h5000);
      conv(3'h5, 1'b0);
      chk({15'h0, eoc_int_n}, 16'h0001);
      $display("test repeat and one shot done");
      frame(16'hA010);
      frame(16'h3000);
      quiet();
      start_n = 1'b0;
      cw(10);
      chk({15'h0, adc_sample}, 16'h0001);
      start_n = 1'b1;
      conv(3'h3, 1'b1);
      chk({15'h0, eoc_int_n}, 16'h0000);
      frame(16'hE000);
      chk({4'h0, rd[15:4]}, {4'h0, 9'h150, 3'h3});
      $display("test extended done");
      give_verdict();
   end
endmodule // ams_seq_top_test
`default_nettype wire
